// file: design/cmd_pkg.sv
// Shared constants and types for the camera mode parameter command block
package cmd_pkg;
   // Frame bytes
   localparam logic [7:0] START_BYTE      = 8'h02;
   localparam logic [7:0] END_BYTE        = 8'h03;
   localparam logic [7:0] ACK_BYTE        = 8'h06;
   localparam logic [7:0] NAK_BYTE        = 8'h15;
   // Command identifiers
   localparam logic [7:0] VIDEO_MODE_ID   = 8'hc0;
   localparam logic [7:0] EXPO_MODE_ID    = 8'ha0;
   // Mode codes
   localparam logic [7:0] VIDEO_DUAL8     = 8'h01;
   localparam logic [7:0] VIDEO_DUAL10    = 8'h03;
   localparam logic [7:0] EXPO_FREE_PROG  = 8'h00;
   localparam logic [7:0] EXPO_TRIG_LEVEL = 8'h04;
   localparam logic [7:0] EXPO_TRIG_PROG  = 8'h05;
   // Values after reset (none printed; chosen)
   localparam logic [7:0] VIDEO_RESET     = 8'h01;
   localparam logic [7:0] EXPO_RESET      = 8'h00;
   // Largest data count; not used, the engine keeps only the first data byte
   localparam int         MAX_DATA        = 4;
   // Timing
   localparam int         CLK_MHZ         = 125;
   localparam int         GAP_MS          = 1000;
   localparam int         SILENCE_MS      = 1500;
   localparam int         GAP_CYCLES      = GAP_MS * 1000 * CLK_MHZ;
   localparam int         SILENCE_CYCLES  = SILENCE_MS * 1000 * CLK_MHZ;
   localparam int         CNT_W           = 28;

   // Decoded frame descriptor
   typedef struct packed {
      logic [7:0] command_identifier;
      logic       read_flag;
      logic [6:0] byte_count;
   } frame_descriptor_type;

   // Active mode settings handed to the datapath
   typedef struct packed {
      logic [7:0] video_output_format_select;
      logic [7:0] exposure_control_select;
   } mode_settings_type;
endpackage

// file: design/byte_gap_timer.sv
// Silence counter measuring time since the last received byte
`timescale 1ns/1ps
module byte_gap_timer (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    restart_i,
   input  wire logic [cmd_pkg::CNT_W-1:0] gap_limit_i,
   input  wire logic [cmd_pkg::CNT_W-1:0] silence_limit_i,
   output logic                         gap_over_o,
   output logic                         silence_over_o
);
   logic [cmd_pkg::CNT_W-1:0] count_r;
   logic [cmd_pkg::CNT_W-1:0] count_nxt;

   // Count up, saturating, cleared by each byte
   always_comb begin
      count_nxt = count_r;
      if (restart_i) begin
         count_nxt = '0;
      end else if (count_r != '1) begin
         count_nxt = count_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign gap_over_o     = (count_r > gap_limit_i);
   assign silence_over_o = (count_r >= silence_limit_i);
endmodule // byte_gap_timer

// file: design/mode_cmd_engine.sv
// Serial command interpreter for video output and exposure mode settings
//
// What this block does
// R1: Write of id c0, flag clear, length 1 stores video mode; no data frame.
// R2: Read of id c0 returns frame c0, flag clear, length 1, mode byte.
// R3: Video mode 01 selects dual-tap 8-bit, 03 dual-tap 10-bit output.
// R4: Write of id a0, flag clear, length 1 stores exposure mode; no frame.
// R5: Read of id a0 returns frame a0, flag clear, length 1, mode byte.
// R6: Exposure 00 free-run, 04 trigger level, 05 trigger programmed timing.
// R7: Frame is 02, two-byte descriptor, data, xor check, 03.
// R8: Check order, count and xor; reply 06 on pass, 15 otherwise.
// R9: Unknown identifiers acknowledged and ignored; written values not range checked.
// R10: Gap over 1 s discards bytes until 1.5 s silence, then idle.
// R11: New mode values take effect from the next captured frame.
`timescale 1ns/1ps
module mode_cmd_engine #(
   parameter int GAP_CYCLES     = cmd_pkg::GAP_CYCLES,
   parameter int SILENCE_CYCLES = cmd_pkg::SILENCE_CYCLES
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic [7:0]                rx_data_i,
   input  wire logic                      rx_valid_i,
   output logic [7:0]                     tx_data_o,
   output logic                           tx_valid_o,
   input  wire logic                      tx_ready_i,
   input  wire logic                      frame_start_i,
   output cmd_pkg::mode_settings_type     active_modes_o,
   output logic                           dual_tap_10bit_o,
   output logic                           trigger_exposure_o,
   output logic                           trigger_level_o
);
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_FRAME_DESCRIPTOR  = 5'b00010,
      ST_DATA  = 5'b00100,
      ST_END   = 5'b01000,
      ST_DROP  = 5'b10000
   } rx_state_type;

   rx_state_type                  state_r, state_nxt;
   logic [1:0]                    frame_descriptor_cnt_r, frame_descriptor_cnt_nxt;
   logic [15:0]                   frame_descriptor_r, frame_descriptor_nxt;
   logic [6:0]                    data_cnt_r, data_cnt_nxt;
   logic [7:0]                    first_data_r, first_data_nxt;
   logic [7:0]                    xor_r, xor_nxt;
   logic                          bad_r, bad_nxt;
   logic [7:0]                    video_r, video_nxt;
   logic [7:0]                    expo_r, expo_nxt;
   cmd_pkg::mode_settings_type    active_r, active_nxt;
   logic [7:0]                    txq_r [0:5];
   logic [7:0]                    txq_nxt [0:5];
   logic [2:0]                    tx_len_r, tx_len_nxt;
   logic [2:0]                    tx_idx_r, tx_idx_nxt;
   cmd_pkg::frame_descriptor_type frame_descriptor;
   logic                          gap_over;
   logic                          silence_over;
   logic                          done;
   logic                          good;
   logic                          tx_busy;
   logic                          tx_end_r, tx_end_nxt;

   assign frame_descriptor    = cmd_pkg::frame_descriptor_type'(frame_descriptor_r);
   assign tx_busy = (tx_idx_r != tx_len_r);

   // Inter-byte timing
   byte_gap_timer gap_timer (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .restart_i       (rx_valid_i),
      .gap_limit_i     (28'(GAP_CYCLES)),
      .silence_limit_i (28'(SILENCE_CYCLES)),
      .gap_over_o      (gap_over),
      .silence_over_o  (silence_over)
   );

   // Frame end check: correct end byte, count matched, xor match
   assign done = (state_r == ST_END) && rx_valid_i && !gap_over && (frame_descriptor_cnt_r == 2'd3);
   assign good = !bad_r && (rx_data_i == cmd_pkg::END_BYTE);  // R8

   // Receive state machine and command execution
   always_comb begin
      state_nxt      = state_r;
      frame_descriptor_cnt_nxt   = frame_descriptor_cnt_r;
      frame_descriptor_nxt       = frame_descriptor_r;
      data_cnt_nxt   = data_cnt_r;
      first_data_nxt = first_data_r;
      xor_nxt        = xor_r;
      bad_nxt        = bad_r;
      video_nxt      = video_r;
      expo_nxt       = expo_r;
      tx_len_nxt     = tx_len_r;
      tx_idx_nxt     = tx_idx_r;
      for (int i = 0; i < 6; i++) begin
         txq_nxt[i] = txq_r[i];
      end
      if (tx_busy && tx_ready_i) begin
         tx_idx_nxt = tx_idx_r + 3'd1;
      end
      if (state_r != ST_IDLE && state_r != ST_DROP && rx_valid_i && gap_over) begin
         state_nxt = ST_DROP;  // R10
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (rx_valid_i && rx_data_i == cmd_pkg::START_BYTE) begin  // R7
                  state_nxt    = ST_FRAME_DESCRIPTOR;
                  frame_descriptor_cnt_nxt = 2'd0;
                  xor_nxt      = 8'h00;
                  bad_nxt      = 1'b0;
               end
            end
            ST_FRAME_DESCRIPTOR: begin
               if (rx_valid_i) begin
                  frame_descriptor_nxt     = {frame_descriptor_r[7:0], rx_data_i};
                  xor_nxt      = xor_r ^ rx_data_i;  // R8
                  frame_descriptor_cnt_nxt = frame_descriptor_cnt_r + 2'd1;
                  if (frame_descriptor_cnt_r == 2'd1) begin
                     data_cnt_nxt = 7'd0;
                     // Reads carry no data bytes even though length is set
                     if (rx_data_i[7] || rx_data_i[6:0] == 7'd0) begin
                        state_nxt = ST_END;
                     end else begin
                        state_nxt = ST_DATA;
                     end
                  end
               end
            end
            ST_DATA: begin
               if (rx_valid_i) begin
                  data_cnt_nxt = data_cnt_r + 7'd1;
                  xor_nxt      = xor_r ^ rx_data_i;  // R8
                  if (data_cnt_r == 7'd0) begin
                     first_data_nxt = rx_data_i;
                  end
                  if (data_cnt_r + 7'd1 == frame_descriptor.byte_count) begin
                     state_nxt = ST_END;
                  end
               end
            end
            ST_END: begin
               if (rx_valid_i) begin
                  // Check byte, then end byte
                  if (!bad_r && frame_descriptor_cnt_r == 2'd2) begin
                     bad_nxt = (rx_data_i != xor_r);  // R8
                     frame_descriptor_cnt_nxt = 2'd3;
                  end else if (frame_descriptor_cnt_r == 2'd2) begin
                     frame_descriptor_cnt_nxt = 2'd3;
                  end else begin
                     state_nxt  = ST_IDLE;
                     txq_nxt[0] = good ? cmd_pkg::ACK_BYTE : cmd_pkg::NAK_BYTE;  // R8
                     tx_len_nxt = 3'd1;
                     tx_idx_nxt = 3'd0;
                     if (good && !frame_descriptor.read_flag && frame_descriptor.byte_count == 7'd1) begin
                        // Writes store without range check; unknown ids ignored
                        if (frame_descriptor.command_identifier == cmd_pkg::VIDEO_MODE_ID) begin
                           video_nxt = first_data_r;  // R1 R9
                        end else if (frame_descriptor.command_identifier == cmd_pkg::EXPO_MODE_ID) begin
                           expo_nxt = first_data_r;  // R4 R9
                        end
                     end else if (good && frame_descriptor.read_flag && frame_descriptor.byte_count == 7'd1) begin
                        if (frame_descriptor.command_identifier == cmd_pkg::VIDEO_MODE_ID ||
                            frame_descriptor.command_identifier == cmd_pkg::EXPO_MODE_ID) begin
                           txq_nxt[1] = cmd_pkg::START_BYTE;
                           txq_nxt[2] = frame_descriptor.command_identifier;  // R2 R5
                           txq_nxt[3] = 8'h01;
                           txq_nxt[4] = (frame_descriptor.command_identifier == cmd_pkg::VIDEO_MODE_ID) ? video_r : expo_r;
                           txq_nxt[5] = frame_descriptor.command_identifier ^ 8'h01 ^ txq_nxt[4];
                           tx_len_nxt = 3'd6;
                        end
                     end
                  end
               end
            end
            ST_DROP: begin
               if (silence_over) begin
                  state_nxt = ST_IDLE;  // R10
               end
            end
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   // Settings move to the datapath only at a frame boundary
   always_comb begin
      active_nxt = active_r;
      if (frame_start_i) begin
         active_nxt.video_output_format_select = video_r;  // R11
         active_nxt.exposure_control_select    = expo_r;   // R11
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r      <= ST_IDLE;
         frame_descriptor_cnt_r   <= 2'd0;
         frame_descriptor_r       <= 16'h0000;
         data_cnt_r   <= 7'd0;
         first_data_r <= 8'h00;
         xor_r        <= 8'h00;
         bad_r        <= 1'b0;
         video_r      <= cmd_pkg::VIDEO_RESET;
         expo_r       <= cmd_pkg::EXPO_RESET;
         active_r     <= {cmd_pkg::VIDEO_RESET, cmd_pkg::EXPO_RESET};
         tx_len_r     <= 3'd0;
         tx_idx_r     <= 3'd0;
         for (int i = 0; i < 6; i++) begin
            txq_r[i] <= 8'h00;
         end
      end else begin
         state_r      <= state_nxt;
         frame_descriptor_cnt_r   <= frame_descriptor_cnt_nxt;
         frame_descriptor_r       <= frame_descriptor_nxt;
         data_cnt_r   <= data_cnt_nxt;
         first_data_r <= first_data_nxt;
         xor_r        <= xor_nxt;
         bad_r        <= bad_nxt;
         video_r      <= video_nxt;
         expo_r       <= expo_nxt;
         active_r     <= active_nxt;
         tx_len_r     <= tx_len_nxt;
         tx_idx_r     <= tx_idx_nxt;
         for (int i = 0; i < 6; i++) begin
            txq_r[i] <= txq_nxt[i];
         end
      end
   end

   // Reply byte stream; end byte closes a data frame
   assign tx_valid_o = tx_busy || tx_end_r;
   assign tx_data_o  = tx_busy ? txq_r[tx_idx_r] : cmd_pkg::END_BYTE;

   always_comb begin
      tx_end_nxt = tx_end_r;
      if (tx_busy && tx_ready_i && tx_idx_r == 3'd5) begin
         tx_end_nxt = 1'b1;
      end else if (tx_end_r && tx_ready_i) begin
         tx_end_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_end_r <= 1'b0;
      end else begin
         tx_end_r <= tx_end_nxt;
      end
   end

   // Mode decode for the datapath
   assign active_modes_o     = active_r;
   assign dual_tap_10bit_o   = (active_r.video_output_format_select == cmd_pkg::VIDEO_DUAL10);  // R3
   assign trigger_exposure_o = (active_r.exposure_control_select == cmd_pkg::EXPO_TRIG_LEVEL) ||
                               (active_r.exposure_control_select == cmd_pkg::EXPO_TRIG_PROG);   // R6
   assign trigger_level_o    = (active_r.exposure_control_select == cmd_pkg::EXPO_TRIG_LEVEL);  // R6

   // Checks
   property p_ack_after_end;
      @(posedge clk_i) disable iff (rst_i)
      done |=> tx_valid_o && (tx_data_o == cmd_pkg::ACK_BYTE || tx_data_o == cmd_pkg::NAK_BYTE);
   endproperty
   a_ack_after_end: assert property (p_ack_after_end) else $error("no ack or nak after frame end"); // R8

   property p_silence_exit;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DROP && !silence_over) |=> state_r == ST_DROP;
   endproperty
   a_silence_exit: assert property (p_silence_exit) else $error("left drop state early"); // R10

   property p_modes_hold;
      @(posedge clk_i) disable iff (rst_i)
      !frame_start_i |=> $stable(active_r);
   endproperty
   a_modes_hold: assert property (p_modes_hold) else $error("mode changed mid frame"); // R11

   property p_write_store;
      @(posedge clk_i) disable iff (rst_i)
      done && good && !frame_descriptor.read_flag && frame_descriptor.byte_count == 7'd1 && frame_descriptor.command_identifier == cmd_pkg::VIDEO_MODE_ID
         |=> video_r == $past(first_data_r) && tx_len_r == 3'd1;
   endproperty
   a_write_store: assert property (p_write_store) else $error("video mode write not stored"); // R1

   sequence s_read_close;
      done && good && frame_descriptor.read_flag && frame_descriptor.byte_count == 7'd1 &&
      (frame_descriptor.command_identifier == cmd_pkg::VIDEO_MODE_ID || frame_descriptor.command_identifier == cmd_pkg::EXPO_MODE_ID);
   endsequence
   property p_read_reply;
      @(posedge clk_i) disable iff (rst_i)
      s_read_close |=> tx_len_r == 3'd6 && txq_r[2] == frame_descriptor.command_identifier && txq_r[3] == 8'h01;
   endproperty
   a_read_reply: assert property (p_read_reply) else $error("read reply frame malformed"); // R2 R5

   property p_nak_on_fault;
      @(posedge clk_i) disable iff (rst_i)
      done && !good |=> tx_valid_o && tx_data_o == cmd_pkg::NAK_BYTE;
   endproperty
   a_nak_on_fault: assert property (p_nak_on_fault) else $error("faulty frame not refused"); // R8
endmodule // mode_cmd_engine

// file: tb/host_model.sv
// Host side model sending command frames and taking reply bytes
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_i,
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o
);
   int stall;

   // Idle lines at time zero
   initial begin
      stall      = 0;
      rx_data_o  = 8'h00;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b0;
   end

   // One byte strobe, then the line shows inverted data
   task automatic send_byte(input logic [7:0] b, input int gap);
      @(posedge clk_i);
      rx_data_o  <= b;
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~b;
      repeat (gap) @(posedge clk_i);
   endtask

   // Start, descriptor, data for writes only, xor check, end
   task automatic send_frame(input logic [7:0] id, input logic rd, input logic [7:0] dat,
                             input logic [7:0] bad_x, input logic [7:0] stop);
      logic [7:0] x;
      x = id ^ {rd, 7'h01};
      send_byte(cmd_pkg::START_BYTE, 1);
      send_byte(id, 1);
      send_byte({rd, 7'h01}, 1);
      if (!rd) begin
         send_byte(dat, 1);
         x = x ^ dat;
      end
      send_byte(x ^ bad_x, 1);
      send_byte(stop, 0);
   endtask

   // Wait for a reply byte, stall if asked, take it when ready is sampled
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tx_valid_i !== 1'b1 && n < 100);
      repeat (stall) @(posedge clk_i);
      tx_ready_o <= 1'b1;
      @(posedge clk_i);
      b  = tx_data_i;
      ok = (tx_valid_i === 1'b1);
      tx_ready_o <= 1'b0;
   endtask
endmodule // host_model

// file: tb/tb_camera_mode_parameter_commands.sv
// Testbench for the mode command interpreter
`timescale 1ns/1ps
module tb_camera_mode_parameter_commands;
   logic                      clk;
   logic                      rst;
   logic                      frame_start;
   logic [7:0]                rx_data;
   logic                      rx_valid;
   logic [7:0]                tx_data;
   logic                      tx_valid;
   logic                      tx_ready;
   cmd_pkg::mode_settings_type modes;
   wire  [2:0]                dec;
   int                        error_cnt;
   int                        cmp_count;
   int                        i;
   logic [7:0]                codes [3];
   logic [2:0]                decs [3];

   host_model host (.clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
                    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

   mode_cmd_engine #(.GAP_CYCLES(20), .SILENCE_CYCLES(30)) dut (
      .clk_i(clk), .rst_i(rst), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
      .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .frame_start_i(frame_start), .active_modes_o(modes), .dual_tap_10bit_o(dec[2]),
      .trigger_exposure_o(dec[1]), .trigger_level_o(dec[0]));

   // Clock at 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Counts, verdict and end of run
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One reply byte with its presence flag
   task automatic expect_byte(input logic [7:0] exp);
      logic [7:0] b;
      logic       ok;
      host.recv_byte(b, ok);
      check({7'h00, ok, b}, {8'h01, exp});
   endtask

   // Write frame and its single reply
   task automatic write_cmd(input logic [7:0] id, input logic [7:0] dat, input logic [7:0] bad_x,
                            input logic [7:0] stop, input logic [7:0] reply);
      host.send_frame(id, 1'b0, dat, bad_x, stop);
      expect_byte(reply);
   endtask

   // Read frame: acknowledge then framed mode byte
   task automatic read_mode(input logic [7:0] id, input logic [7:0] exp);
      logic [7:0] want [7];
      want = '{cmd_pkg::ACK_BYTE, cmd_pkg::START_BYTE, id, 8'h01, exp, id ^ 8'h01 ^ exp, cmd_pkg::END_BYTE};
      host.send_frame(id, 1'b1, 8'h00, 8'h00, cmd_pkg::END_BYTE);
      for (int k = 0; k < 7; k++) expect_byte(want[k]);
   endtask

   // No reply byte for a while
   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk);
         seen = seen | (tx_valid === 1'b1);
      end
      check({15'h0000, seen}, 16'h0000);
   endtask

   // Captured frame start pulse, then let outputs settle
   task automatic new_frame();
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end

   // Main sequence
   initial begin
      error_cnt   = 0;
      cmp_count   = 0;
      rst         = 1'b1;
      frame_start = 1'b0;
      codes = '{cmd_pkg::EXPO_FREE_PROG, cmd_pkg::EXPO_TRIG_LEVEL, cmd_pkg::EXPO_TRIG_PROG};
      decs  = '{3'b000, 3'b011, 3'b010};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(modes, {cmd_pkg::VIDEO_RESET, cmd_pkg::EXPO_RESET});
      read_mode(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_RESET);
      read_mode(cmd_pkg::EXPO_MODE_ID, cmd_pkg::EXPO_RESET);
      $display("test reset values done");
      // Video mode held until the next frame
      write_cmd(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_DUAL10, 8'h00, cmd_pkg::END_BYTE, cmd_pkg::ACK_BYTE);
      check(modes, {cmd_pkg::VIDEO_RESET, cmd_pkg::EXPO_RESET});
      new_frame();
      check(modes, {cmd_pkg::VIDEO_DUAL10, cmd_pkg::EXPO_RESET});
      check({13'h0000, dec}, 16'h0004);
      read_mode(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_DUAL10);
      write_cmd(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_DUAL8, 8'h00, cmd_pkg::END_BYTE, cmd_pkg::ACK_BYTE);
      new_frame();
      check({13'h0000, dec}, 16'h0000);
      $display("test video mode done");
      // Every exposure code, slow host
      host.stall = 3;
      for (i = 2; i >= 0; i--) begin
         write_cmd(cmd_pkg::EXPO_MODE_ID, codes[i], 8'h00, cmd_pkg::END_BYTE, cmd_pkg::ACK_BYTE);
         new_frame();
         check(modes, {cmd_pkg::VIDEO_DUAL8, codes[i]});
         check({13'h0000, dec}, {13'h0000, decs[i]});
         read_mode(cmd_pkg::EXPO_MODE_ID, codes[i]);
      end
      host.stall = 0;
      $display("test exposure modes done");
      // Broken check byte and end byte refused
      write_cmd(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_DUAL10, 8'h01, cmd_pkg::END_BYTE, cmd_pkg::NAK_BYTE);
      write_cmd(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_DUAL10, 8'h00, 8'h04, cmd_pkg::NAK_BYTE);
      read_mode(cmd_pkg::VIDEO_MODE_ID, cmd_pkg::VIDEO_DUAL8);
      $display("test refusals done");
      // Unknown identifier and unlisted value
      write_cmd(8'h55, 8'h12, 8'h00, cmd_pkg::END_BYTE, cmd_pkg::ACK_BYTE);
      host.send_frame(8'h55, 1'b1, 8'h00, 8'h00, cmd_pkg::END_BYTE);
      expect_byte(cmd_pkg::ACK_BYTE);
      quiet(30);
      write_cmd(cmd_pkg::VIDEO_MODE_ID, 8'h07, 8'h00, cmd_pkg::END_BYTE, cmd_pkg::ACK_BYTE);
      read_mode(cmd_pkg::VIDEO_MODE_ID, 8'h07);
      $display("test unknown and unlisted done");
      // Long byte gap discards the frame until silence
      host.send_byte(cmd_pkg::START_BYTE, 25);
      host.send_frame(cmd_pkg::EXPO_MODE_ID, 1'b1, 8'h00, 8'h00, cmd_pkg::END_BYTE);
      quiet(40);
      read_mode(cmd_pkg::EXPO_MODE_ID, cmd_pkg::EXPO_FREE_PROG);
      $display("test byte gap done");
      print_verdict();
   end
endmodule // tb_camera_mode_parameter_commands
